// file: src/ipf_defs.svh
// offsets, fields, opcodes and timing counts for the flash programming host
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH

// own user-side register map (byte addresses)
`define IPF_REG_CTRL        9'h000
`define IPF_REG_ADDR        9'h004
`define IPF_REG_STAT        9'h008
`define IPF_BUF_SEL_BIT     8
`define IPF_CTRL_OP_LSB     0
`define IPF_CTRL_OP_MSB     1
`define IPF_CTRL_HOLD_BIT   2
`define IPF_CTRL_FIN_BIT    3
`define IPF_CTRL_GO_BIT     8
`define IPF_CTRL_RST        4'h0
`define IPF_STAT_BUSY_BIT   0
`define IPF_STAT_DONE_BIT   1
`define IPF_STAT_TMO_BIT    2
`define IPF_STAT_FDONE_BIT  3

// device register map as seen on the device port (byte addresses)
`define IPF_DEV_PGM_EN      12'h000
`define IPF_DEV_FPCFG       12'h004
`define IPF_DEV_LINK        12'h008
`define IPF_DEV_PGM_CFG     12'h00C
`define IPF_DEV_PGM_CMD     12'h010
`define IPF_DEV_PGM_STAT    12'h014
`define IPF_DEV_DATA        12'h100
`define IPF_FPCFG_MODE_BIT  0
`define IPF_FPCFG_HOLD_BIT  1
`define IPF_FPCFG_DONE_BIT  2
`define IPF_DSTAT_INSTR_BIT 0
`define IPF_DSTAT_PAGE_BIT  1
`define IPF_MODE_SPI        1'b0
`define IPF_CMD_START       32'h0000_0001

// flash instruction codes placed into the configuration register
`define IPF_OPC_PROGRAM     8'h02
`define IPF_OPC_CHIP_ERASE  8'hC7
`define IPF_OPC_SECT_ERASE  8'hD8
`define IPF_OPC_READ        8'h03

// one page: 256 bytes as 64 words
`define IPF_PAGE_BYTES      256
`define IPF_PAGE_WORDS      64
`define IPF_LAST_WORD       6'h3F

// done-flag poll limit; each poll takes three cycles
`define IPF_POLL_LIMIT      32'd50000000

`endif

// file: src/ipf_pkg.sv
// types for the flash programming host
package ipf_pkg;

	typedef enum logic [1:0] {
		IPF_OP_PROGRAM = 2'h0,
		IPF_OP_CHIP_ER = 2'h1,
		IPF_OP_SECT_ER = 2'h2,
		IPF_OP_READ    = 2'h3
	} ipf_op_t;

	// gray codes along the usual path
	typedef enum logic [4:0] {
		IPF_S_IDLE     = 5'h00,
		IPF_S_PGM_ON   = 5'h01,
		IPF_S_LINK_OFF = 5'h03,
		IPF_S_MODE     = 5'h02,
		IPF_S_FILL     = 5'h06,
		IPF_S_CFG      = 5'h07,
		IPF_S_CMD      = 5'h05,
		IPF_S_POLL_RD  = 5'h04,
		IPF_S_POLL_CHK = 5'h0C,
		IPF_S_DRN_RD   = 5'h0D,
		IPF_S_DRN_CAP  = 5'h0F,
		IPF_S_PGM_OFF  = 5'h0E,
		IPF_S_REL_HOLD = 5'h0A,
		IPF_S_LINK_ON  = 5'h0B,
		IPF_S_STAT_RD  = 5'h09,
		IPF_S_STAT_CHK = 5'h08
	} ipf_state_t;

endpackage

// file: src/ipf_host.sv
// host sequencer that programs, erases and reads the configuration flash
// Notes on behaviour
// - programming mode and SPI configuration mode set before each flash job.
// - reconfigure-hold set when requested before flash operations.
// - host link to the user FPGA disabled before reconfigure-hold is set.
// - page buffer holds one 256-byte page; one program moves at most that.
// - start address and page-write instruction loaded before the start.
// - a command register write launches the configured instruction.
// - wait for instruction-done or page-data-done before anything further; the host goes on after POLL_LIMIT polls and sets the timeout bit.
// - software repeats fill, address, start, wait until the image is written.
// - clearing programming mode returns the flash to the user FPGA.
// - chip erase: load erase instruction, start, wait for done flags.
// - sector erase: address written, erase instruction set, then started.
// - sector erases repeat, each waiting for completion first.
// - read: load start address and read instruction, start, wait for done.
`timescale 1ns/1ps
`include "ipf_defs.svh"

module ipf_host #(
	parameter logic [31:0] POLL_LIMIT = `IPF_POLL_LIMIT
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [8:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic      [11:0] o_dev_addr,
	output logic      [31:0] o_dev_wdata,
	output logic             o_dev_wr,
	output logic             o_dev_rd,
	input  wire logic [31:0] i_dev_rdata
);
	import ipf_pkg::*;

	// one flash page
	logic [31:0] page_mem [0:`IPF_PAGE_WORDS-1];

	ipf_state_t  state_q, state_d;
	logic [3:0]  ctrl_q, ctrl_d;
	logic [23:0] faddr_q, faddr_d;
	logic [5:0]  idx_q, idx_d;
	logic        wt_q, wt_d;
	logic [31:0] poll_q, poll_d;
	logic        done_q, done_d;
	logic        tmo_q, tmo_d;
	logic        fdone_q, fdone_d;
	logic [31:0] rdata_d;
	logic [11:0] dev_addr_d;
	logic [31:0] dev_wdata_d;
	logic        dev_wr_d;
	logic        dev_rd_d;
	logic        mem_we;
	logic [5:0]  mem_idx;
	logic [31:0] mem_wdata;
	ipf_op_t     op;
	logic        hold;
	logic        fin;
	logic        busy;
	logic        buf_hit;
	logic [7:0]  opcode;

	assign op      = ipf_op_t'(ctrl_q[`IPF_CTRL_OP_MSB:`IPF_CTRL_OP_LSB]);
	assign hold    = ctrl_q[`IPF_CTRL_HOLD_BIT];
	assign fin     = ctrl_q[`IPF_CTRL_FIN_BIT];
	assign busy    = (state_q != IPF_S_IDLE);
	assign buf_hit = i_addr[`IPF_BUF_SEL_BIT];

	always_comb begin
		case (op)
			IPF_OP_PROGRAM: opcode = `IPF_OPC_PROGRAM;
			IPF_OP_CHIP_ER: opcode = `IPF_OPC_CHIP_ERASE;
			IPF_OP_SECT_ER: opcode = `IPF_OPC_SECT_ERASE;
			IPF_OP_READ:    opcode = `IPF_OPC_READ;
			default:        opcode = `IPF_OPC_READ;
		endcase
	end

	always_comb begin
		state_d     = state_q;
		ctrl_d      = ctrl_q;
		faddr_d     = faddr_q;
		idx_d       = idx_q;
		wt_d        = wt_q;
		poll_d      = poll_q;
		done_d      = done_q;
		tmo_d       = tmo_q;
		fdone_d     = fdone_q;
		dev_addr_d  = o_dev_addr;
		dev_wdata_d = o_dev_wdata;
		dev_wr_d    = 1'b0;
		dev_rd_d    = 1'b0;
		rdata_d     = 32'h0000_0000;
		mem_we      = 1'b0;
		mem_idx     = i_addr[7:2];
		mem_wdata   = i_wdata;

		// user port; user writes to settings and buffer are dropped while a sequence runs
		if (i_rd) begin
			if (buf_hit) begin
				rdata_d = page_mem[i_addr[7:2]];
			end else if (i_addr == `IPF_REG_CTRL) begin
				rdata_d = {28'h000_0000, ctrl_q};
			end else if (i_addr == `IPF_REG_ADDR) begin
				rdata_d = {8'h00, faddr_q};
			end else if (i_addr == `IPF_REG_STAT) begin
				rdata_d = {28'h000_0000, fdone_q, tmo_q, done_q, busy};
			end
		end
		if (i_wr && !busy) begin
			if (buf_hit) begin
				mem_we = 1'b1;
			end else if (i_addr == `IPF_REG_ADDR) begin
				faddr_d = i_wdata[23:0];
			end else if (i_addr == `IPF_REG_CTRL) begin
				ctrl_d = i_wdata[3:0];
				if (i_wdata[`IPF_CTRL_GO_BIT]) begin
					done_d  = 1'b0;
					tmo_d   = 1'b0;
					idx_d   = 6'h00;
					state_d = IPF_S_PGM_ON;
				end
			end
		end

		case (state_q)
			IPF_S_IDLE: begin
			end
			IPF_S_PGM_ON: begin
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_PGM_EN;
				dev_wdata_d = 32'h0000_0001;
				state_d     = hold ? IPF_S_LINK_OFF : IPF_S_MODE;
			end
			IPF_S_LINK_OFF: begin
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_LINK;
				dev_wdata_d = 32'h0000_0000;
				state_d     = IPF_S_MODE;
			end
			IPF_S_MODE: begin
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_FPCFG;
				dev_wdata_d = 32'h0000_0000;
				dev_wdata_d[`IPF_FPCFG_MODE_BIT] = `IPF_MODE_SPI;
				dev_wdata_d[`IPF_FPCFG_HOLD_BIT] = hold;
				state_d = (op == IPF_OP_PROGRAM) ? IPF_S_FILL : IPF_S_CFG;
			end
			IPF_S_FILL: begin
				// the device programs from offset zero, so copy from word 0 up
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_DATA + {4'h0, idx_q, 2'b00};
				dev_wdata_d = page_mem[idx_q];
				idx_d       = idx_q + 6'h01;
				if (idx_q == `IPF_LAST_WORD) begin
					state_d = IPF_S_CFG;
				end
			end
			IPF_S_CFG: begin
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_PGM_CFG;
				dev_wdata_d = {opcode, faddr_q};
				state_d     = IPF_S_CMD;
			end
			IPF_S_CMD: begin
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_PGM_CMD;
				dev_wdata_d = `IPF_CMD_START;
				poll_d      = 32'h0000_0000;
				state_d     = IPF_S_POLL_RD;
			end
			IPF_S_POLL_RD: begin
				dev_rd_d   = 1'b1;
				dev_addr_d = `IPF_DEV_PGM_STAT;
				wt_d       = 1'b0;
				state_d    = IPF_S_POLL_CHK;
			end
			IPF_S_POLL_CHK: begin
				// strobe leaves the flop now; its data arrive one cycle later
				wt_d = 1'b1;
				if (wt_q) begin
					poll_d = poll_q + 32'h0000_0001;
					if (i_dev_rdata[`IPF_DSTAT_INSTR_BIT] ||
					    i_dev_rdata[`IPF_DSTAT_PAGE_BIT]) begin
						idx_d   = 6'h00;
						state_d = (op == IPF_OP_READ) ? IPF_S_DRN_RD :
						          (fin ? IPF_S_PGM_OFF : IPF_S_STAT_RD);
					end else if (poll_q >= POLL_LIMIT - 32'h0000_0001) begin
						tmo_d   = 1'b1;
						state_d = fin ? IPF_S_PGM_OFF : IPF_S_STAT_RD;
					end else begin
						state_d = IPF_S_POLL_RD;
					end
				end
			end
			IPF_S_DRN_RD: begin
				dev_rd_d   = 1'b1;
				dev_addr_d = `IPF_DEV_DATA + {4'h0, idx_q, 2'b00};
				wt_d       = 1'b0;
				state_d    = IPF_S_DRN_CAP;
			end
			IPF_S_DRN_CAP: begin
				wt_d = 1'b1;
				if (wt_q) begin
					mem_we    = 1'b1;
					mem_idx   = idx_q;
					mem_wdata = i_dev_rdata;
					idx_d     = idx_q + 6'h01;
					if (idx_q == `IPF_LAST_WORD) begin
						state_d = fin ? IPF_S_PGM_OFF : IPF_S_STAT_RD;
					end else begin
						state_d = IPF_S_DRN_RD;
					end
				end
			end
			IPF_S_PGM_OFF: begin
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_PGM_EN;
				dev_wdata_d = 32'h0000_0000;
				state_d     = hold ? IPF_S_REL_HOLD : IPF_S_STAT_RD;
			end
			IPF_S_REL_HOLD: begin
				// releasing the hold starts the user FPGA reconfiguration
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_FPCFG;
				dev_wdata_d = 32'h0000_0000;
				state_d     = IPF_S_LINK_ON;
			end
			IPF_S_LINK_ON: begin
				dev_wr_d    = 1'b1;
				dev_addr_d  = `IPF_DEV_LINK;
				dev_wdata_d = 32'h0000_0001;
				state_d     = IPF_S_STAT_RD;
			end
			IPF_S_STAT_RD: begin
				dev_rd_d   = 1'b1;
				dev_addr_d = `IPF_DEV_FPCFG;
				wt_d       = 1'b0;
				state_d    = IPF_S_STAT_CHK;
			end
			IPF_S_STAT_CHK: begin
				wt_d = 1'b1;
				if (wt_q) begin
					fdone_d = i_dev_rdata[`IPF_FPCFG_DONE_BIT];
					done_d  = 1'b1;
					state_d = IPF_S_IDLE;
				end
			end
			default: begin
				state_d = IPF_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q     <= IPF_S_IDLE;
			ctrl_q      <= `IPF_CTRL_RST;
			faddr_q     <= 24'h00_0000;
			idx_q       <= 6'h00;
			wt_q        <= 1'b0;
			poll_q      <= 32'h0000_0000;
			done_q      <= 1'b0;
			tmo_q       <= 1'b0;
			fdone_q     <= 1'b0;
			o_rdata     <= 32'h0000_0000;
			o_dev_addr  <= 12'h000;
			o_dev_wdata <= 32'h0000_0000;
			o_dev_wr    <= 1'b0;
			o_dev_rd    <= 1'b0;
		end else begin
			state_q     <= state_d;
			ctrl_q      <= ctrl_d;
			faddr_q     <= faddr_d;
			idx_q       <= idx_d;
			wt_q        <= wt_d;
			poll_q      <= poll_d;
			done_q      <= done_d;
			tmo_q       <= tmo_d;
			fdone_q     <= fdone_d;
			o_rdata     <= rdata_d;
			o_dev_addr  <= dev_addr_d;
			o_dev_wdata <= dev_wdata_d;
			o_dev_wr    <= dev_wr_d;
			o_dev_rd    <= dev_rd_d;
		end
	end

	// page store has no reset; contents are undefined until written
	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			page_mem[mem_idx] <= mem_wdata;
		end
	end

endmodule

// file: verif/ipf_host_properties.sv
// concurrent checks on the ports of the flash programming host
`timescale 1ns/1ps
`include "ipf_defs.svh"
module ipf_host_properties #(
	parameter logic [31:0] POLL_LIMIT = 32'd20
) (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic [8:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [11:0] o_dev_addr,
	input wire logic [31:0] o_dev_wdata,
	input wire logic        o_dev_wr,
	input wire logic        o_dev_rd,
	input wire logic [31:0] i_dev_rdata
);
	logic fill_q;
	logic fill_d;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// remembers whether the last device access touched the data space
	always_comb begin
		fill_d = fill_q;
		if (o_dev_wr || o_dev_rd)
			fill_d = o_dev_addr[11:8] == 4'h1;
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			fill_q <= 1'b0;
		else
			fill_q <= fill_d;
	end
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside its cycle");
	strobe_excl_a: assert property (!(o_dev_wr && o_dev_rd))
		else $error("device strobes together");
	cmd_after_cfg_a: assert property (
		o_dev_wr && o_dev_addr == `IPF_DEV_PGM_CMD |->
		o_dev_wdata == `IPF_CMD_START && $past(o_dev_wr) &&
		$past(o_dev_addr) == `IPF_DEV_PGM_CFG)
		else $error("start not right after configuration");
	cfg_opcode_a: assert property (
		o_dev_wr && o_dev_addr == `IPF_DEV_PGM_CFG |->
		o_dev_wdata[31:24] inside {`IPF_OPC_PROGRAM, `IPF_OPC_CHIP_ERASE,
		`IPF_OPC_SECT_ERASE, `IPF_OPC_READ})
		else $error("bad instruction code");
	read_gap_a: assert property (
		o_dev_rd |=> (!o_dev_rd && !o_dev_wr) [*2])
		else $error("device read not followed by idle");
	mode_spi_a: assert property (
		o_dev_wr && o_dev_addr == `IPF_DEV_FPCFG |->
		o_dev_wdata[0] == `IPF_MODE_SPI)
		else $error("configuration mode not serial");
	link_then_hold_a: assert property (
		o_dev_wr && o_dev_addr == `IPF_DEV_LINK && !o_dev_wdata[0] |->
		##[1:3] (o_dev_wr && o_dev_addr == `IPF_DEV_FPCFG && o_dev_wdata[1]))
		else $error("hold not set after link disable");
	fill_start_a: assert property (
		o_dev_wr && o_dev_addr[11:8] == 4'h1 && !fill_q |->
		o_dev_addr == `IPF_DEV_DATA)
		else $error("page fill not from offset zero");
	cover property (o_dev_wr && o_dev_addr == `IPF_DEV_PGM_CFG &&
		o_dev_wdata[31:24] == `IPF_OPC_CHIP_ERASE);
	cover property (o_dev_wr && o_dev_addr == `IPF_DEV_PGM_CFG &&
		o_dev_wdata[31:24] == `IPF_OPC_READ);
	cover property (o_dev_wr && o_dev_addr == `IPF_DEV_DATA);
	cover property (o_dev_wr && o_dev_addr == `IPF_DEV_LINK &&
		!o_dev_wdata[0]);
endmodule

bind ipf_host ipf_host_properties #(.POLL_LIMIT(POLL_LIMIT)) chk (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_dev_addr(o_dev_addr),
	.o_dev_wdata(o_dev_wdata), .o_dev_wr(o_dev_wr), .o_dev_rd(o_dev_rd),
	.i_dev_rdata(i_dev_rdata));

// file: verif/ipf_dev_model.sv
// behavioural model of the programming device and its flash page
`timescale 1ns/1ps
`include "ipf_defs.svh"
module ipf_dev_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [11:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [1:0]  i_slow,
	input  wire logic        i_fdone,
	output logic      [31:0] o_rdata
);
	logic [31:0] pg_q [64];
	logic [31:0] fl_q [64];
	logic [31:0] cfg_q;
	logic [1:0]  fp_q;
	logic        pgm_q;
	// the device drives the configuration clock itself; not modelled here
	localparam int CFG_CLK_KHZ = 53200;
	logic        link_q;
	logic [1:0]  st_q;
	logic [7:0]  cnt_q;
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pgm_q <= 1'b0;
			link_q <= 1'b1;
			fp_q <= 2'h0;
			st_q <= 2'h0;
			cnt_q <= 8'h0;
			o_rdata <= 32'h0;
		end else begin
			if (i_wr) case (i_addr)
				`IPF_DEV_PGM_EN: pgm_q <= i_wdata[0];
				`IPF_DEV_FPCFG: fp_q <= i_wdata[1:0];
				`IPF_DEV_LINK: link_q <= i_wdata[0];
				`IPF_DEV_PGM_CFG: cfg_q <= i_wdata;
				`IPF_DEV_PGM_CMD: if (pgm_q && cnt_q == 8'h0) begin
					st_q <= 2'h0;
					// a count of 250 outlasts the bench's poll limit
					cnt_q <= (i_slow == 2'h2) ? 8'd250 :
						(i_slow == 2'h1) ? 8'd40 : 8'd2;
				end
				default: if (i_addr[11:8] == 4'h1)
					pg_q[i_addr[7:2]] <= i_wdata;
			endcase
			if (cnt_q == 8'h1) begin
				st_q <= {(cfg_q[31:24] inside {`IPF_OPC_PROGRAM, `IPF_OPC_READ}),
					1'b1};
				for (int i = 0; i < 64; i++) case (cfg_q[31:24])
					`IPF_OPC_PROGRAM: fl_q[i] <= pg_q[i];
					`IPF_OPC_READ: pg_q[i] <= fl_q[i];
					default: fl_q[i] <= 32'hFFFF_FFFF;
				endcase
			end
			if (cnt_q != 8'h0)
				cnt_q <= cnt_q - 8'h1;
			// a released bus inverts its value each cycle, so the old answer returns every other cycle
			if (i_rd) case (i_addr)
				`IPF_DEV_FPCFG: o_rdata <= {29'h0, i_fdone, fp_q};
				`IPF_DEV_PGM_STAT: o_rdata <= {30'h0, st_q};
				default: o_rdata <= pg_q[i_addr[7:2]];
			endcase
			else
				o_rdata <= ~o_rdata;
		end
	end
endmodule

// file: verif/ipf_host_tb.sv
// self-checking bench for the flash programming host
`timescale 1ns/1ps
`include "ipf_defs.svh"
module ipf_host_tb;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [8:0]  i_addr = 9'h0;
	logic [31:0] i_wdata = 32'h0;
	logic [31:0] o_rdata, dev_rdata, dev_wdata, v;
	logic [11:0] dev_addr;
	logic        dev_wr, dev_rd;
	logic [1:0]  slow = 2'h0;
	logic        fdone = 1'b1;
	int          fails = 0, check_count = 0, cyc = 0;

	ipf_host #(.POLL_LIMIT(32'd20)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata),
		.o_dev_wr(dev_wr), .o_dev_rd(dev_rd), .i_dev_rdata(dev_rdata));
	ipf_dev_model dev (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(dev_addr),
		.i_wdata(dev_wdata), .i_wr(dev_wr), .i_rd(dev_rd), .i_slow(slow),
		.i_fdone(fdone), .o_rdata(dev_rdata));

	initial forever #20 i_clk = ~i_clk;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			end_of_test();
		end
	end

	function automatic logic [31:0] pat(int i);
		return 32'hA5C3_0000 ^ 32'(i * 32'h0101_0111);
	endfunction
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [8:0] a, logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [8:0] a, output logic [31:0] q);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 q = o_rdata;
	endtask
	task automatic rdc(string n, logic [8:0] a, logic [31:0] e);
		rd(a, v);
		cmp(n, e, v);
	endtask
	// go, then an address write that busy must drop, then poll
	task automatic run(logic [31:0] ctl);
		int k;
		wr(`IPF_REG_CTRL, ctl);
		wr(`IPF_REG_ADDR, 32'h00FF_FFFF);
		k = 0;
		do begin
			rd(`IPF_REG_STAT, v);
			k++;
		end while (v[0] !== 1'b0 && k < 400);
	endtask

	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rdc("ctrl", `IPF_REG_CTRL, 32'h0);
		rdc("stat", `IPF_REG_STAT, 32'h0);
		rdc("unmapped", 9'h00C, 32'h0);
		cmp("pgm_en", 32'h0, {31'h0, dev.pgm_q});
		$display("test reset done");
		for (int i = 0; i < 64; i++) wr(9'(256 + 4 * i), pat(i));
		wr(`IPF_REG_ADDR, 32'h0000_1000);
		run(32'h0000_010C);
		cmp("stat", 32'hA, v);
		rdc("addr", `IPF_REG_ADDR, 32'h0000_1000);
		cmp("cfg", 32'h0200_1000, dev.cfg_q);
		cmp("release", 32'h2, {29'h0, dev.pgm_q, dev.link_q, dev.fp_q[1]});
		for (int i = 0; i < 64; i++) cmp("flash", pat(i), dev.fl_q[i]);
		$display("test program done");
		for (int i = 0; i < 64; i++) wr(9'(256 + 4 * i), 32'h0);
		run(32'h0000_010B);
		cmp("stat", 32'hA, v);
		cmp("cfg", 32'h0300_1000, dev.cfg_q);
		for (int i = 0; i < 64; i++) rdc("page", 9'(256 + 4 * i), pat(i));
		$display("test read done");
		fdone <= 1'b0;
		slow <= 2'h1;
		run(32'h0000_0109);
		cmp("stat", 32'h2, v);
		cmp("erased", 32'hFFFF_FFFF, dev.fl_q[0]);
		$display("test chip erase done");
		for (int s = 1; s < 3; s++) begin
			wr(`IPF_REG_ADDR, 32'(s * 32'h0001_0000));
			run(32'h0000_010A);
			cmp("stat", 32'h2, v);
			cmp("cfg", 32'hD800_0000 | 32'(s * 32'h0001_0000), dev.cfg_q);
		end
		$display("test sector erase done");
		slow <= 2'h2;
		run(32'h0000_0109);
		cmp("stat", 32'h6, v);
		$display("test timeout done");
		end_of_test();
	end
endmodule
